// [hdl/cct_params.svh]
// constants of the completion credit tracker: field positions, widths, granularities
// assumes inclusion by every design file that needs a figure; holds definitions only
`ifndef CCT_PARAMS_SVH
`define CCT_PARAMS_SVH

// link control copy bit that picks the completion boundary size
`define CCT_RCB_SEL_BIT 3
// log2 of the completion boundary in bytes: 64 when the bit is clear, 128 when set
`define CCT_RCB_LOG2_SMALL 3'h6
`define CCT_RCB_LOG2_LARGE 3'h7
// log2 of one data credit in bytes (16)
`define CCT_CREDIT_LOG2 3'h4
// finest data scaling: 0 counts 16-byte credits, 1 quadwords, 2 dwords
`define CCT_MAX_SCALE 2'h2
// default widths and sizes
`define CCT_HDR_W 8
`define CCT_DATA_W 14
`define CCT_TAG_W 5
`define CCT_BEAT_BYTES 8
// bytes per receive beat allowed by the address walker
`define CCT_BEAT_DW 4
`define CCT_BEAT_QW 8

`endif

// [hdl/cct_pkg.sv]
// types and shared arithmetic of the completion credit tracker
// assumes nothing beyond a SystemVerilog compiler
package cct_pkg;

  typedef enum logic [1:0] {
    per_packet_method,
    per_boundary_method,
    per_data_credit_method,
    line_rate_method
  } cct_method_t;

  typedef enum logic [1:0] {
    kind_mem_read,
    kind_io_read,
    kind_io_write
  } cct_kind_t;

  // number of 2**lg blocks touched by len bytes starting at addr
  function automatic logic [13:0] cct_span(input logic [11:0] addr, input logic [12:0] len,
                                           input logic [2:0] lg);
    logic [13:0] mask;
    mask = (14'h1 << lg) - 14'h1;
    return ((({2'h0, addr} & mask) + {1'h0, len} + mask) >> lg);
  endfunction

endpackage

// [hdl/cct_credit_counter.sv]
// one outstanding-credit counter: adds allocations and subtracts releases in one cycle
// assumes the caller never adds beyond the counter's range
`include "cct_params.svh"
module cct_credit_counter #(
  parameter int W = `CCT_HDR_W
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // changes
  input wire logic [W-1:0] add_i,
  input wire logic [W-1:0] sub_i,
  // state
  output logic [W-1:0] count_o
);

  logic [W-1:0] count_r;
  logic [W:0] sum;
  logic [W-1:0] count_nxt;

  if (W < 2 || W > 14) begin : g_chk
    $error("credit counter width out of range");
  end

  // both changes land together; release clamps at zero for malformed completions
  always_comb begin
    sum = {1'b0, count_r} + {1'b0, add_i};
    if ({1'b0, sub_i} > sum) begin
      count_nxt = '0;
    end else begin
      count_nxt = W'(sum - {1'b0, sub_i});
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end

  assign count_o = count_r;

endmodule

// [hdl/cct_addr_walker.sv]
// running byte address of a completion: counts boundary and data units begun per beat
// assumes one start pulse with the first beat and one beat pulse per later full beat
`include "cct_params.svh"
module cct_addr_walker #(
  parameter int BEAT_BYTES = `CCT_BEAT_BYTES
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // completion stream
  input wire logic start_i,
  input wire logic beat_i,
  input wire logic [6:0] lower_addr_i,
  // granularity
  input wire logic [2:0] rcb_log2_i,
  input wire logic [2:0] unit_log2_i,
  // counts this cycle
  output logic hdr_step_o,
  output logic [2:0] data_step_o
);

  localparam logic [7:0] BEAT = 8'(BEAT_BYTES);

  logic [7:0] running_byte_address_r;
  logic active_r;
  logic [7:0] first_end;
  logic [7:0] next_addr;
  logic [7:0] rcb_mask;
  logic [7:0] unit_mask;

  if (BEAT_BYTES != `CCT_BEAT_DW && BEAT_BYTES != `CCT_BEAT_QW) begin : g_chk
    $error("beat must be one dword or one quadword");
  end

  always_comb begin
    rcb_mask = (8'h1 << rcb_log2_i) - 8'h1;
    unit_mask = (8'h1 << unit_log2_i) - 8'h1;
    first_end = ({1'b0, lower_addr_i} & ~(BEAT - 8'h1)) + BEAT;
    next_addr = running_byte_address_r + BEAT;
    hdr_step_o = 1'b0;
    data_step_o = '0;
    if (start_i) begin
      hdr_step_o = 1'b1;
      data_step_o = 3'(8'h1 + ((first_end - 8'h1) >> unit_log2_i) - ({1'b0, lower_addr_i} >> unit_log2_i));
    end else if (beat_i && active_r) begin
      hdr_step_o = (next_addr & rcb_mask) == 8'h0;
      if ((8'h1 << unit_log2_i) >= BEAT) begin
        data_step_o = {2'b0, (next_addr & unit_mask) == 8'h0};
      end else begin
        data_step_o = 3'(BEAT >> unit_log2_i);
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      running_byte_address_r <= '0;
    end else if (start_i) begin
      running_byte_address_r <= {1'b0, lower_addr_i} & ~(BEAT - 8'h1);
    end else if (beat_i && active_r) begin
      running_byte_address_r <= next_addr;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      active_r <= 1'b0;
    end else if (start_i) begin
      active_r <= 1'b1;
    end
  end

endmodule

// [hdl/cct_tracker.sv]
// completion credit tracker: meters receive completion space for outgoing non-posted requests
// assumes the user holds a request until granted and reports completions as they arrive
`include "cct_params.svh"

// Summary of operation
// - both outstanding counters clear on reset
// - header need spans boundary blocks touched
// - data need spans data units (16 bytes at scale 0); io write zero
// - grant only within capacities, then add needs; line rate grants any, adds none
// - store each request's needs by tag
// - packet method releases stored needs at end
// - credits per boundary is boundary over credit
// - boundary method data need is header times that
// - each boundary begun releases one header, block
// - crossings from lower address plus length
// - or walk running address counting boundary rollovers
// - optional io read one, io write zero
// - io policy looks up completion tag's kind
// - data method header release per boundary begun
// - data method data release per credit begun
// - or walk running address counting credit rollovers
// - scale data capacity to quadword or dword units
// - line rate mode keeps receive ready asserted
module cct_tracker #(
  parameter int HDR_W = `CCT_HDR_W,
  parameter int DATA_W = `CCT_DATA_W,
  parameter int TAG_W = `CCT_TAG_W,
  parameter int BEAT_BYTES = `CCT_BEAT_BYTES,
  parameter bit USE_WALKER = 1'b0
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // configuration
  input wire cct_pkg::cct_method_t method_i,
  input wire logic [15:0] link_control_copy_i,
  input wire logic io_policy_i,
  input wire logic [1:0] data_scale_i,
  input wire logic [HDR_W-1:0] hdr_capacity_i,
  input wire logic [DATA_W-1:0] data_capacity_i,
  // non-posted request
  input wire logic req_valid_i,
  input wire logic [11:0] req_addr_i,
  input wire logic [12:0] req_len_i,
  input wire cct_pkg::cct_kind_t req_kind_i,
  input wire logic [TAG_W-1:0] req_tag_i,
  output logic req_grant_o,
  output logic [HDR_W-1:0] req_hdr_credits_o,
  output logic [DATA_W-1:0] req_data_credits_o,
  // completion receive
  input wire logic cpl_start_i,
  input wire logic cpl_beat_i,
  input wire logic cpl_last_i,
  input wire logic [6:0] cpl_lower_addr_i,
  input wire logic [12:0] cpl_bytes_i,
  input wire logic [TAG_W-1:0] cpl_tag_i,
  input wire logic user_rx_ready_i,
  output logic rx_sink_ready_o,
  // state
  output logic [HDR_W-1:0] hdr_outstanding_o,
  output logic [DATA_W-1:0] data_outstanding_o
);

  localparam int DEPTH = 2 ** TAG_W;

  if (HDR_W < 2 || HDR_W > 14 || DATA_W < 2 || DATA_W > 14 || TAG_W < 1 || TAG_W > 8) begin : g_chk
    $error("tracker widths out of range");
  end

  // granularity
  logic [1:0] scale;
  logic [2:0] rcb_log2;
  logic [2:0] unit_log2;
  logic [2:0] bnd_shift;
  logic line_mode;

  always_comb begin
    scale = (data_scale_i > `CCT_MAX_SCALE) ? `CCT_MAX_SCALE : data_scale_i;
    unit_log2 = `CCT_CREDIT_LOG2 - {1'b0, scale};
    rcb_log2 = link_control_copy_i[`CCT_RCB_SEL_BIT] ? `CCT_RCB_LOG2_LARGE : `CCT_RCB_LOG2_SMALL;
    bnd_shift = rcb_log2 - unit_log2;
    line_mode = method_i == cct_pkg::line_rate_method;
  end

  // counters
  logic [HDR_W-1:0] hdr_cnt;
  logic [DATA_W-1:0] data_cnt;
  logic [HDR_W-1:0] hdr_add;
  logic [DATA_W-1:0] data_add;
  logic [HDR_W-1:0] hdr_rel;
  logic [DATA_W-1:0] data_rel;

  cct_credit_counter #(.W(HDR_W)) u_hdr_cnt (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .add_i(hdr_add),
    .sub_i(hdr_rel),
    .count_o(hdr_cnt)
  );

  cct_credit_counter #(.W(DATA_W)) u_data_cnt (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .add_i(data_add),
    .sub_i(data_rel),
    .count_o(data_cnt)
  );

  assign hdr_outstanding_o = hdr_cnt;
  assign data_outstanding_o = data_cnt;

  // request needs
  logic [13:0] req_hdr_w;
  logic [13:0] req_data_w;
  logic [15:0] hdr_sum;
  logic [15:0] data_sum;
  logic [15:0] data_cap_eff;
  logic fits;
  logic take;
  logic req_grant_r;

  always_comb begin
    req_hdr_w = cct_pkg::cct_span(req_addr_i, req_len_i, rcb_log2);
    if (method_i == cct_pkg::per_boundary_method) begin
      if (io_policy_i && req_kind_i == cct_pkg::kind_io_read) begin
        req_data_w = 14'h1 << scale;
      end else if (io_policy_i && req_kind_i == cct_pkg::kind_io_write) begin
        req_data_w = '0;
      end else begin
        req_data_w = req_hdr_w << bnd_shift;
      end
    end else if (req_kind_i == cct_pkg::kind_io_write) begin
      req_data_w = '0;
    end else begin
      req_data_w = cct_pkg::cct_span(req_addr_i, req_len_i, unit_log2);
    end
  end

  always_comb begin
    data_cap_eff = 16'(data_capacity_i) << scale;
    hdr_sum = 16'(hdr_cnt) + {2'h0, req_hdr_w};
    data_sum = 16'(data_cnt) + {2'h0, req_data_w};
    fits = (hdr_sum <= 16'(hdr_capacity_i)) && (data_sum <= data_cap_eff);
    take = req_valid_i && !req_grant_r && (line_mode || fits);
    hdr_add = (take && !line_mode) ? HDR_W'(req_hdr_w) : '0;
    data_add = (take && !line_mode) ? DATA_W'(req_data_w) : '0;
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      req_grant_r <= 1'b0;
    end else begin
      req_grant_r <= take;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      req_hdr_credits_o <= '0;
      req_data_credits_o <= '0;
    end else if (take) begin
      req_hdr_credits_o <= HDR_W'(req_hdr_w);
      req_data_credits_o <= DATA_W'(req_data_w);
    end
  end

  assign req_grant_o = req_grant_r;

  // per-tag record of needs and request kind
  logic [HDR_W-1:0] tag_hdr_r [DEPTH];
  logic [DATA_W-1:0] tag_data_r [DEPTH];
  cct_pkg::cct_kind_t tag_kind_r [DEPTH];

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        tag_hdr_r[i] <= '0;
        tag_data_r[i] <= '0;
        tag_kind_r[i] <= cct_pkg::kind_mem_read;
      end
    end else if (take) begin
      tag_hdr_r[req_tag_i] <= HDR_W'(req_hdr_w);
      tag_data_r[req_tag_i] <= DATA_W'(req_data_w);
      tag_kind_r[req_tag_i] <= req_kind_i;
    end
  end

  // completion release
  logic io_cpl;
  logic walk_start;
  logic walk_hdr;
  logic [2:0] walk_data;
  logic [13:0] cpl_hdr_w;
  logic [13:0] cpl_data_w;

  cct_addr_walker #(.BEAT_BYTES(BEAT_BYTES)) u_walker (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .start_i(walk_start),
    .beat_i(cpl_beat_i),
    .lower_addr_i(cpl_lower_addr_i),
    .rcb_log2_i(rcb_log2),
    .unit_log2_i(unit_log2),
    .hdr_step_o(walk_hdr),
    .data_step_o(walk_data)
  );

  always_comb begin
    io_cpl = io_policy_i && method_i == cct_pkg::per_boundary_method &&
             tag_kind_r[cpl_tag_i] != cct_pkg::kind_mem_read;
    walk_start = USE_WALKER && cpl_start_i && !io_cpl;
    cpl_hdr_w = cct_pkg::cct_span({5'h0, cpl_lower_addr_i}, cpl_bytes_i, rcb_log2);
    cpl_data_w = cct_pkg::cct_span({5'h0, cpl_lower_addr_i}, cpl_bytes_i, unit_log2);
    hdr_rel = '0;
    data_rel = '0;
    case (method_i)
      cct_pkg::per_packet_method: begin
        if (cpl_start_i && cpl_last_i) begin
          hdr_rel = tag_hdr_r[cpl_tag_i];
          data_rel = tag_data_r[cpl_tag_i];
        end
      end
      cct_pkg::per_boundary_method: begin
        if (cpl_start_i && io_cpl) begin
          hdr_rel = HDR_W'(1);
          data_rel = (tag_kind_r[cpl_tag_i] == cct_pkg::kind_io_read) ? DATA_W'(14'h1 << scale) : '0;
        end else if (USE_WALKER) begin
          hdr_rel = HDR_W'(walk_hdr);
          data_rel = walk_hdr ? DATA_W'(14'h1 << bnd_shift) : '0;
        end else if (cpl_start_i) begin
          hdr_rel = HDR_W'(cpl_hdr_w);
          data_rel = DATA_W'(cpl_hdr_w << bnd_shift);
        end
      end
      cct_pkg::per_data_credit_method: begin
        if (USE_WALKER) begin
          hdr_rel = HDR_W'(walk_hdr);
          data_rel = DATA_W'(walk_data);
        end else if (cpl_start_i) begin
          hdr_rel = HDR_W'(cpl_hdr_w);
          data_rel = DATA_W'(cpl_data_w);
        end
      end
      default: begin
        hdr_rel = '0;
        data_rel = '0;
      end
    endcase
  end

  // receive ready: held high in line rate mode so the device can drain at line rate
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      rx_sink_ready_o <= 1'b0;
    end else begin
      rx_sink_ready_o <= line_mode || user_rx_ready_i;
    end
  end

  // checks
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  counters_clear_a: assert property ($rose(reset_n_i) |-> hdr_cnt == '0 && data_cnt == '0)
    else $error("counters not clear after reset");

  grant_in_capacity_a: assert property (req_grant_o && $past(method_i) != cct_pkg::line_rate_method
                                        |-> 16'(hdr_cnt) <= 16'($past(hdr_capacity_i)))
    else $error("grant exceeded header capacity");

  data_in_capacity_a: assert property (req_grant_o && $past(method_i) != cct_pkg::line_rate_method
                                       |-> 16'(data_cnt) <= $past(data_cap_eff))
    else $error("grant exceeded data capacity");

  grant_single_a: assert property (req_grant_o |=> !req_grant_o)
    else $error("grant longer than one cycle");

  line_grant_a: assert property (req_valid_i && !req_grant_o && line_mode |=> req_grant_o)
    else $error("line rate request not granted");

  same_cycle_add_a: assert property (hdr_add != '0 && hdr_rel != '0 &&
                                     16'(hdr_cnt) + 16'(hdr_add) >= 16'(hdr_rel)
                                     |=> hdr_cnt == $past(hdr_cnt) + $past(hdr_add) - $past(hdr_rel))
    else $error("allocation and release lost one");

  data_same_cycle_a: assert property (data_add != '0 && data_rel != '0 &&
                                      16'(data_cnt) + 16'(data_add) >= 16'(data_rel)
                                      |=> data_cnt == $past(data_cnt) + $past(data_add) - $past(data_rel))
    else $error("data allocation and release lost one");

  no_underflow_a: assert property (hdr_add == '0 && hdr_rel > hdr_cnt |=> hdr_cnt == '0)
    else $error("header counter went below zero");

  data_no_underflow_a: assert property (data_add == '0 && data_rel > data_cnt |=> data_cnt == '0)
    else $error("data counter went below zero");

  header_need_a: assert property (take ##1 req_grant_o |-> 14'(req_hdr_credits_o) ==
                                  cct_pkg::cct_span($past(req_addr_i), $past(req_len_i), $past(rcb_log2)))
    else $error("header need wrong");

  boundary_data_a: assert property (take && method_i == cct_pkg::per_boundary_method && !io_policy_i
                                    |=> 14'(req_data_credits_o) == 14'(req_hdr_credits_o) << $past(bnd_shift))
    else $error("boundary data need not header multiple");

  io_write_zero_a: assert property (take && req_kind_i == cct_pkg::kind_io_write &&
                                    method_i != cct_pkg::per_boundary_method |=> req_data_credits_o == '0)
    else $error("io write reserved data");

  packet_hold_a: assert property (method_i == cct_pkg::per_packet_method && !(cpl_start_i && cpl_last_i)
                                  && !take |=> hdr_cnt == $past(hdr_cnt) && data_cnt == $past(data_cnt))
    else $error("packet credits released early");

  packet_release_a: assert property (method_i == cct_pkg::per_packet_method && cpl_start_i && cpl_last_i
                                     && !take && hdr_cnt >= tag_hdr_r[cpl_tag_i] && data_cnt >= tag_data_r[cpl_tag_i]
                                     |=> hdr_cnt == $past(hdr_cnt) - $past(tag_hdr_r[cpl_tag_i])
                                     && data_cnt == $past(data_cnt) - $past(tag_data_r[cpl_tag_i]))
    else $error("packet credits not released at last completion");

  io_release_a: assert property (io_cpl && cpl_start_i && !take && hdr_cnt != '0
                                 |=> hdr_cnt == $past(hdr_cnt) - HDR_W'(1))
    else $error("io completion header release wrong");

  line_ready_a: assert property ((method_i == cct_pkg::line_rate_method) [*2] |-> rx_sink_ready_o)
    else $error("receive ready dropped in line rate mode");

  line_no_count_a: assert property (line_mode |=> hdr_cnt == $past(hdr_cnt) && data_cnt == $past(data_cnt))
    else $error("line rate mode changed a counter");

  counters_still_a: assert property (!take && !cpl_start_i && !cpl_beat_i
                                     |=> hdr_cnt == $past(hdr_cnt) && data_cnt == $past(data_cnt))
    else $error("counter changed with no request or completion");

  boundary_size_a: assert property ((16'h1 << rcb_log2) == (link_control_copy_i[`CCT_RCB_SEL_BIT] ? 16'h80 : 16'h40)
                                    && (16'h1 << bnd_shift) == ((16'h1 << rcb_log2) >> unit_log2))
    else $error("boundary size wrong");

  record_kept_a: assert property (take |=> tag_hdr_r[$past(req_tag_i)] == req_hdr_credits_o
                                  && tag_data_r[$past(req_tag_i)] == req_data_credits_o)
    else $error("request needs not stored");

endmodule

// [verif/cct_cpl_model.sv]
// completion source standing in for the device's receive side
// assumes go_i pulses once per request range and the bench waits for busy_o to fall
module cct_cpl_model (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // range to answer
  input wire logic go_i,
  input wire logic [11:0] addr_i,
  input wire logic [12:0] len_i,
  input wire logic [4:0] tag_i,
  input wire logic rcb_sel_i,
  input wire logic [3:0] gap_i,
  // completion stream
  output logic start_o,
  output logic last_o,
  output logic [6:0] lower_o,
  output logic [12:0] bytes_o,
  output logic [4:0] tag_o,
  output logic busy_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [11:0] cur_r;
  logic [12:0] rem_r;
  logic [4:0] tag_r;
  logic [3:0] wait_r;
  logic [12:0] room;
  logic [12:0] chunk;
  // pieces end on the boundary: 128 bytes with the select bit set, else 64
  assign room = rcb_sel_i ? 13'h80 - {6'h0, cur_r[6:0]} : 13'h40 - {7'h0, cur_r[5:0]};
  assign chunk = (rem_r < room) ? rem_r : room;
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      {start_o, last_o, lower_o, bytes_o, tag_o, busy_o} <= '0;
      {cur_r, rem_r, tag_r, wait_r} <= '0;
    end else if (go_i) begin
      cur_r <= addr_i;
      rem_r <= len_i;
      tag_r <= tag_i;
      busy_o <= 1'b1;
      start_o <= 1'b0;
      wait_r <= 4'h0;
    end else if (busy_o && wait_r == 4'h0) begin
      // one boundary block per completion keeps the buffer from being oversubscribed
      start_o <= 1'b1;
      last_o <= (chunk == rem_r);
      lower_o <= cur_r[6:0];
      bytes_o <= chunk;
      tag_o <= tag_r;
      cur_r <= cur_r + chunk[11:0];
      rem_r <= rem_r - chunk;
      busy_o <= (chunk != rem_r);
      wait_r <= gap_i;
    end else begin
      // fields are not held between completions
      start_o <= 1'b0;
      last_o <= 1'b0;
      lower_o <= ~lower_o;
      bytes_o <= ~bytes_o;
      tag_o <= ~tag_o;
      if (wait_r != 4'h0) begin
        wait_r <= wait_r - 4'h1;
      end
    end
  end
endmodule

// [verif/tb_top.sv]
// self-checking bench of the completion credit tracker
// assumes the design sources and the completion source model are compiled first
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam cct_pkg::cct_kind_t mr = cct_pkg::kind_mem_read;
  localparam cct_pkg::cct_kind_t ior = cct_pkg::kind_io_read;
  localparam cct_pkg::cct_kind_t iow = cct_pkg::kind_io_write;
  logic core_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  cct_pkg::cct_method_t method = cct_pkg::per_packet_method;
  logic [15:0] lcc = 16'h0;
  logic io_pol = 1'b0;
  logic [1:0] scale = 2'h0;
  logic [7:0] hcap = 8'h0;
  logic [13:0] dcap = 14'h0;
  logic req_valid = 1'b0;
  logic [11:0] req_addr = 12'h0;
  logic [12:0] req_len = 13'h1;
  cct_pkg::cct_kind_t req_kind = mr;
  logic [4:0] req_tag = 5'h0;
  logic user_rdy = 1'b0;
  logic go = 1'b0;
  logic [3:0] gap = 4'h0;
  logic [11:0] m_addr = 12'h0;
  logic [12:0] m_len = 13'h0;
  logic [4:0] m_tag = 5'h0;
  logic grant, c_start, c_last, m_busy, sink_rdy;
  logic [6:0] c_lower;
  logic [12:0] c_bytes;
  logic [4:0] c_tag;
  logic [7:0] hdr_need, hdr_out;
  logic [13:0] data_need, data_out;
  int miscompares = 0;
  int check_count = 0;

  always #50 core_clk_i = ~core_clk_i;

  cct_tracker uut (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .method_i(method), .link_control_copy_i(lcc),
    .io_policy_i(io_pol), .data_scale_i(scale), .hdr_capacity_i(hcap), .data_capacity_i(dcap),
    .req_valid_i(req_valid), .req_addr_i(req_addr), .req_len_i(req_len), .req_kind_i(req_kind),
    .req_tag_i(req_tag), .req_grant_o(grant), .req_hdr_credits_o(hdr_need), .req_data_credits_o(data_need),
    .cpl_start_i(c_start), .cpl_beat_i(1'b0), .cpl_last_i(c_last), .cpl_lower_addr_i(c_lower),
    .cpl_bytes_i(c_bytes), .cpl_tag_i(c_tag), .user_rx_ready_i(user_rdy), .rx_sink_ready_o(sink_rdy),
    .hdr_outstanding_o(hdr_out), .data_outstanding_o(data_out)
  );

  cct_cpl_model partner (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .go_i(go), .addr_i(m_addr), .len_i(m_len),
    .tag_i(m_tag), .rcb_sel_i(lcc[3]), .gap_i(gap), .start_o(c_start), .last_o(c_last),
    .lower_o(c_lower), .bytes_o(c_bytes), .tag_o(c_tag), .busy_o(m_busy)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    if (miscompares == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic give_up;
    check(32'h0, 32'h1);
    finish_test;
  endtask

  task automatic do_reset(input cct_pkg::cct_method_t m, input logic [15:0] l, input logic [7:0] hc,
                          input logic [13:0] dc, input logic [1:0] sc);
    @(posedge core_clk_i);
    reset_n_i <= 1'b0;
    method <= m;
    lcc <= l;
    hcap <= hc;
    dcap <= dc;
    scale <= sc;
    repeat (5) @(posedge core_clk_i);
    #1;
    check(hdr_out, 0);
    check(data_out, 0);
    @(posedge core_clk_i);
    reset_n_i <= 1'b1;
  endtask

  // present a request, wait for its grant, compare needs and counters
  task automatic request(input logic [11:0] a, input logic [12:0] n, input cct_pkg::cct_kind_t k,
                         input logic [4:0] t, input int eh, input int ed, input int oh, input int od);
    int i;
    @(posedge core_clk_i);
    req_valid <= 1'b1;
    req_addr <= a;
    req_len <= n;
    req_kind <= k;
    req_tag <= t;
    for (i = 0; i < 20 && grant !== 1'b1; i++) begin
      @(posedge core_clk_i);
      #1;
    end
    if (grant !== 1'b1) give_up;
    check(hdr_need, eh);
    check(data_need, ed);
    check(hdr_out, oh);
    check(data_out, od);
    @(posedge core_clk_i);
    req_valid <= 1'b0;
    #1;
    check(grant, 0);
  endtask

  task automatic launch(input logic [11:0] a, input logic [12:0] n, input logic [4:0] t);
    @(posedge core_clk_i);
    go <= 1'b1;
    m_addr <= a;
    m_len <= n;
    m_tag <= t;
    @(posedge core_clk_i);
    go <= 1'b0;
  endtask

  // let the partner answer a range; hold >= 0 demands the header count stay put meanwhile
  task automatic send(input logic [11:0] a, input logic [12:0] n, input logic [4:0] t, input int hold);
    int i;
    launch(a, n, t);
    #1;
    for (i = 0; i < 80 && m_busy !== 1'b0; i++) begin
      if (hold >= 0) check(hdr_out, hold);
      @(posedge core_clk_i);
      #1;
    end
    if (m_busy !== 1'b0) give_up;
    @(posedge core_clk_i);
    #1;
  endtask

  task automatic s_packet;
    do_reset(cct_pkg::per_packet_method, 16'h0, 8'h40, 14'h100, 2'h0);
    gap <= 4'h3;
    request(12'h7c, 13'h8, mr, 5'h3, 2, 2, 2, 2);
    request(12'h10, 13'h4, iow, 5'h4, 1, 0, 3, 2);
    send(12'h7c, 13'h8, 5'h3, 3);
    check(hdr_out, 1);
    check(data_out, 0);
    send(12'h10, 13'h4, 5'h4, 1);
    check(hdr_out, 0);
    gap <= 4'h0;
  endtask

  task automatic s_refuse;
    int i;
    do_reset(cct_pkg::per_data_credit_method, 16'h0, 8'h2, 14'h2, 2'h0);
    request(12'h7c, 13'h8, mr, 5'h3, 2, 2, 2, 2);
    @(posedge core_clk_i);
    req_valid <= 1'b1;
    req_addr <= 12'h0;
    req_len <= 13'h4;
    for (i = 0; i < 8; i++) begin
      @(posedge core_clk_i);
      #1;
      check(grant, 0);
    end
    @(posedge core_clk_i);
    req_valid <= 1'b0;
    send(12'h7c, 13'h8, 5'h3, -1);
    check(hdr_out, 0);
    check(data_out, 0);
    request(12'h0, 13'h4, mr, 5'h5, 1, 1, 1, 1);
  endtask

  task automatic s_data;
    do_reset(cct_pkg::per_data_credit_method, 16'h0, 8'h40, 14'h100, 2'h0);
    request(12'h38, 13'h50, mr, 5'h1, 3, 6, 3, 6);
    request(12'h0, 13'h10, mr, 5'h2, 1, 1, 4, 7);
    send(12'h38, 13'h50, 5'h1, -1);
    check(hdr_out, 1);
    check(data_out, 1);
  endtask

  task automatic s_boundary;
    do_reset(cct_pkg::per_boundary_method, 16'h8, 8'h40, 14'h100, 2'h0);
    request(12'h30, 13'h20, mr, 5'h2, 1, 8, 1, 8);
    request(12'h7c, 13'h8, mr, 5'h6, 2, 16, 3, 24);
    send(12'h7c, 13'h8, 5'h6, -1);
    check(hdr_out, 1);
    check(data_out, 8);
    do_reset(cct_pkg::per_boundary_method, 16'h0, 8'h40, 14'h100, 2'h0);
    request(12'h30, 13'h20, mr, 5'h2, 2, 8, 2, 8);
  endtask

  task automatic s_io;
    do_reset(cct_pkg::per_boundary_method, 16'h0, 8'h40, 14'h100, 2'h0);
    io_pol <= 1'b1;
    request(12'h0, 13'h4, ior, 5'h7, 1, 1, 1, 1);
    request(12'h4, 13'h4, iow, 5'h8, 1, 0, 2, 1);
    request(12'h40, 13'h4, mr, 5'h9, 1, 4, 3, 5);
    send(12'h4, 13'h4, 5'h8, -1);
    check(hdr_out, 2);
    check(data_out, 5);
    send(12'h0, 13'h4, 5'h7, -1);
    check(hdr_out, 1);
    check(data_out, 4);
    @(posedge core_clk_i);
    io_pol <= 1'b0;
  endtask

  task automatic s_scale;
    do_reset(cct_pkg::per_data_credit_method, 16'h0, 8'h40, 14'h2, 2'h1);
    request(12'h70, 13'h20, mr, 5'h1, 2, 4, 2, 4);
    do_reset(cct_pkg::per_data_credit_method, 16'h0, 8'h40, 14'h2, 2'h2);
    request(12'h70, 13'h20, mr, 5'h1, 2, 8, 2, 8);
  endtask

  task automatic s_same;
    do_reset(cct_pkg::per_data_credit_method, 16'h0, 8'h40, 14'h100, 2'h0);
    request(12'h0, 13'h10, mr, 5'h1, 1, 1, 1, 1);
    launch(12'h0, 13'h10, 5'h1);
    request(12'h20, 13'h10, mr, 5'h2, 1, 1, 1, 1);
    send(12'h40, 13'h80, 5'h3, -1);
    check(hdr_out, 0);
    check(data_out, 0);
  endtask

  task automatic s_line;
    do_reset(cct_pkg::line_rate_method, 16'h0, 8'h0, 14'h0, 2'h0);
    @(posedge core_clk_i);
    #1;
    check(sink_rdy, 1);
    request(12'h0, 13'h4, mr, 5'h1, 1, 1, 0, 0);
    send(12'h0, 13'h40, 5'h1, -1);
    check(hdr_out, 0);
    do_reset(cct_pkg::per_packet_method, 16'h0, 8'h40, 14'h100, 2'h0);
    @(posedge core_clk_i);
    #1;
    check(sink_rdy, 0);
    @(posedge core_clk_i);
    user_rdy <= 1'b1;
    @(posedge core_clk_i);
    #1;
    check(sink_rdy, 1);
  endtask

  initial begin
    s_packet;
    s_refuse;
    s_data;
    s_boundary;
    s_io;
    s_scale;
    s_same;
    s_line;
    finish_test;
  end
endmodule
